// file: ipr_pkg.sv
// Constants and types shared by the interrupt priority register bank
package ipr_pkg;

	// Register indices as printed; byte address on the bus is four times these
	localparam logic [31:0] IDX_EXT_LOW = 32'hffff8348;
	localparam logic [31:0] IDX_EXT_HIGH = 32'hffff834a;
	localparam logic [31:0] IDX_DMA = 32'h0fff834c;
	localparam logic [31:0] IDX_TIMER01 = 32'hffff834e;
	localparam logic [31:0] IDX_TIMER2 = 32'hffff8350;
	localparam logic [31:0] IDX_SERIAL = 32'hffff8352;
	localparam logic [31:0] IDX_CONV_CMP = 32'hffff8354;
	localparam logic [31:0] IDX_WDT_BUS = 32'hffff8356;

	// Bus geometry: the low 16 index bits tell the registers apart
	localparam int ADDR_W = 18;
	localparam int IDX_W = 16;
	localparam int NUM_REGS = 8;
	localparam int REG_W = 16;

	// Slot numbers inside the bank
	localparam logic [2:0] SLOT_EXT_LOW = 3'h0;
	localparam logic [2:0] SLOT_EXT_HIGH = 3'h1;
	localparam logic [2:0] SLOT_DMA = 3'h2;
	localparam logic [2:0] SLOT_TIMER01 = 3'h3;
	localparam logic [2:0] SLOT_TIMER2 = 3'h4;
	localparam logic [2:0] SLOT_SERIAL = 3'h5;
	localparam logic [2:0] SLOT_CONV_CMP = 3'h6;
	localparam logic [2:0] SLOT_WDT_BUS = 3'h7;

	// Writable-bit masks; zero bits are reserved, read as zero
	localparam logic [15:0] MASK_EXT_LOW = 16'hffff;
	localparam logic [15:0] MASK_EXT_HIGH = 16'h00ff;
	localparam logic [15:0] MASK_DMA = 16'hff00;
	localparam logic [15:0] MASK_TIMER01 = 16'hffff;
	localparam logic [15:0] MASK_TIMER2 = 16'hff00;
	localparam logic [15:0] MASK_SERIAL = 16'h00ff;
	localparam logic [15:0] MASK_CONV_CMP = 16'hf0ff;
	localparam logic [15:0] MASK_WDT_BUS = 16'hf000;

	localparam logic [15:0] PRIO_RESET = 16'h0000;

	// Priority field positions (lsb) and width
	localparam int FLD_W = 4;
	localparam int FLD_3 = 12;
	localparam int FLD_2 = 8;
	localparam int FLD_1 = 4;
	localparam int FLD_0 = 0;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_DECERR = 2'h3;

	typedef enum logic [1:0] {
		WR_COLLECT = 2'b00,
		WR_COMMIT = 2'b01,
		WR_RESP = 2'b10
	} ipr_wr_state_t;

	typedef enum logic {
		RD_IDLE = 1'b0,
		RD_RESP = 1'b1
	} ipr_rd_state_t;

	typedef struct packed {
		ipr_wr_state_t wst;
		logic aw_got;
		logic w_got;
		logic [ADDR_W-1:0] waddr;
		logic [REG_W-1:0] wdata;
		logic [1:0] wstrb;
		logic [1:0] bresp;
		ipr_rd_state_t rst;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} ipr_bus_state_t;

	typedef struct packed {
		logic [REG_W-1:0] value;
	} ipr_slot_state_t;

endpackage

// file: ipr_prio_reg.sv
// One 16-bit priority register with per-byte strobes and a writable mask
module ipr_prio_reg #(
	parameter logic [15:0] WMASK = 16'hffff
) (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Write port
	input wire logic wr_en,
	input wire logic [1:0] wr_strb,
	input wire logic [15:0] wr_data,
	// Stored value
	output logic [15:0] value
);

	ipr_pkg::ipr_slot_state_t st_r;
	ipr_pkg::ipr_slot_state_t st_nxt;
	logic [15:0] lane_mask;

	always_comb begin
		st_nxt = st_r;
		lane_mask = {{8{wr_strb[1]}}, {8{wr_strb[0]}}} & WMASK;
		if (wr_en) begin
			// Reserved bits never take a write and so stay zero
			st_nxt.value = (st_r.value & ~lane_mask) | (wr_data & lane_mask);
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r.value <= ipr_pkg::PRIO_RESET;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign value = st_r.value & WMASK;

endmodule

// file: ipr_priority_bank.sv
// Interrupt priority register bank behind an AXI4-Lite slave
//
// Design decision made here: the AXI4-Lite slave port.
module ipr_priority_bank (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// AXI4-Lite write address
	input wire logic [17:0] s_axi_awaddr,
	input wire logic [2:0] s_axi_awprot,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [17:0] s_axi_araddr,
	input wire logic [2:0] s_axi_arprot,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// External request priority levels
	output logic [3:0] external_request_0_prio,
	output logic [3:0] external_request_1_prio,
	output logic [3:0] external_request_2_prio,
	output logic [3:0] external_request_3_prio,
	output logic [3:0] external_request_6_prio,
	output logic [3:0] external_request_7_prio,
	// DMA channel priority levels
	output logic [3:0] dma_channel_0_prio,
	output logic [3:0] dma_channel_1_prio,
	// Multifunction timer priority levels, two fields per channel
	output logic [3:0] timer_channel_0_prio_a,
	output logic [3:0] timer_channel_0_prio_b,
	output logic [3:0] timer_channel_1_prio_a,
	output logic [3:0] timer_channel_1_prio_b,
	output logic [3:0] timer_channel_2_prio_a,
	output logic [3:0] timer_channel_2_prio_b,
	// Serial channel priority levels
	output logic [3:0] serial_channel_0_prio,
	output logic [3:0] serial_channel_1_prio,
	// Converter and compare timer priority levels
	output logic [3:0] converter_prio,
	output logic [3:0] compare_timer_0_prio,
	output logic [3:0] compare_timer_1_prio,
	// Shared watchdog timer and bus controller priority level
	output logic [3:0] watchdog_buscontrol_prio
);

	localparam int AW = ipr_pkg::ADDR_W;
	localparam int RW = ipr_pkg::REG_W;

	ipr_pkg::ipr_bus_state_t st_r;
	ipr_pkg::ipr_bus_state_t st_nxt;

	logic [RW-1:0] prio [ipr_pkg::NUM_REGS];
	logic [ipr_pkg::NUM_REGS-1:0] slot_wr;
	logic [3:0] wr_sel;
	logic [3:0] rd_sel;
	logic aw_take;
	logic w_take;
	logic ar_take;

	// Map a byte address onto {hit, slot}; word aligned, low two bits ignored
	function automatic logic [3:0] decode(input logic [AW-1:0] addr);
		logic [ipr_pkg::IDX_W-1:0] idx;
		idx = addr[AW-1:2];
		case (idx)
			ipr_pkg::IDX_EXT_LOW[15:0]: decode = {1'b1, ipr_pkg::SLOT_EXT_LOW};
			ipr_pkg::IDX_EXT_HIGH[15:0]: decode = {1'b1, ipr_pkg::SLOT_EXT_HIGH};
			ipr_pkg::IDX_DMA[15:0]: decode = {1'b1, ipr_pkg::SLOT_DMA};
			ipr_pkg::IDX_TIMER01[15:0]: decode = {1'b1, ipr_pkg::SLOT_TIMER01};
			ipr_pkg::IDX_TIMER2[15:0]: decode = {1'b1, ipr_pkg::SLOT_TIMER2};
			ipr_pkg::IDX_SERIAL[15:0]: decode = {1'b1, ipr_pkg::SLOT_SERIAL};
			ipr_pkg::IDX_CONV_CMP[15:0]: decode = {1'b1, ipr_pkg::SLOT_CONV_CMP};
			ipr_pkg::IDX_WDT_BUS[15:0]: decode = {1'b1, ipr_pkg::SLOT_WDT_BUS};
			default: decode = 4'h0;
		endcase
	endfunction

	// Pick one 4-bit priority field out of a register
	function automatic logic [3:0] field(input logic [RW-1:0] r, input int lsb);
		field = r[lsb +: ipr_pkg::FLD_W];
	endfunction

	// Handshake outputs are combinational from the phase registers
	assign s_axi_awready = (st_r.wst == ipr_pkg::WR_COLLECT) && !st_r.aw_got;
	assign s_axi_wready = (st_r.wst == ipr_pkg::WR_COLLECT) && !st_r.w_got;
	assign s_axi_bvalid = (st_r.wst == ipr_pkg::WR_RESP);
	assign s_axi_bresp = st_r.bresp;
	assign s_axi_arready = (st_r.rst == ipr_pkg::RD_IDLE);
	assign s_axi_rvalid = (st_r.rst == ipr_pkg::RD_RESP);
	assign s_axi_rdata = st_r.rdata;
	assign s_axi_rresp = st_r.rresp;

	assign aw_take = s_axi_awvalid && s_axi_awready;
	assign w_take = s_axi_wvalid && s_axi_wready;
	assign ar_take = s_axi_arvalid && s_axi_arready;

	assign wr_sel = decode(st_r.waddr);
	assign rd_sel = decode(s_axi_araddr);

	// One write strobe per slot, only in the commit cycle
	always_comb begin
		slot_wr = '0;
		if (st_r.wst == ipr_pkg::WR_COMMIT && wr_sel[3]) begin
			slot_wr[wr_sel[2:0]] = 1'b1;
		end
	end

	always_comb begin
		st_nxt = st_r;
		case (st_r.wst)
			ipr_pkg::WR_COLLECT: begin
				// Address and data may arrive in either order
				if (aw_take) begin
					st_nxt.aw_got = 1'b1;
					st_nxt.waddr = s_axi_awaddr;
				end
				if (w_take) begin
					st_nxt.w_got = 1'b1;
					st_nxt.wdata = s_axi_wdata[RW-1:0];
					// Upper lanes hold no bits; any width of access works
					st_nxt.wstrb = s_axi_wstrb[1:0];
				end
				if ((st_r.aw_got || aw_take) && (st_r.w_got || w_take)) begin
					st_nxt.wst = ipr_pkg::WR_COMMIT;
				end
			end
			ipr_pkg::WR_COMMIT: begin
				st_nxt.aw_got = 1'b0;
				st_nxt.w_got = 1'b0;
				st_nxt.bresp = wr_sel[3] ? ipr_pkg::RESP_OKAY :
					ipr_pkg::RESP_DECERR;
				st_nxt.wst = ipr_pkg::WR_RESP;
			end
			ipr_pkg::WR_RESP: begin
				if (s_axi_bready) begin
					st_nxt.wst = ipr_pkg::WR_COLLECT;
				end
			end
			default: begin
				st_nxt.wst = ipr_pkg::WR_COLLECT;
			end
		endcase
		case (st_r.rst)
			ipr_pkg::RD_IDLE: begin
				if (ar_take) begin
					st_nxt.rst = ipr_pkg::RD_RESP;
					if (rd_sel[3]) begin
						// Reserved bits and upper half read as zero
						st_nxt.rdata = {16'h0000, prio[rd_sel[2:0]]};
						st_nxt.rresp = ipr_pkg::RESP_OKAY;
					end else begin
						st_nxt.rdata = 32'h0000_0000;
						st_nxt.rresp = ipr_pkg::RESP_DECERR;
					end
				end
			end
			ipr_pkg::RD_RESP: begin
				if (s_axi_rready) begin
					st_nxt.rst = ipr_pkg::RD_IDLE;
				end
			end
			default: begin
				st_nxt.rst = ipr_pkg::RD_IDLE;
			end
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	// The bank: writable masks carry each register's reserved layout
	ipr_prio_reg #(.WMASK(ipr_pkg::MASK_EXT_LOW)) u_ext_low (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(slot_wr[ipr_pkg::SLOT_EXT_LOW]),
		.wr_strb(st_r.wstrb),
		.wr_data(st_r.wdata),
		.value(prio[ipr_pkg::SLOT_EXT_LOW])
	);
	ipr_prio_reg #(.WMASK(ipr_pkg::MASK_EXT_HIGH)) u_ext_high (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(slot_wr[ipr_pkg::SLOT_EXT_HIGH]),
		.wr_strb(st_r.wstrb),
		.wr_data(st_r.wdata),
		.value(prio[ipr_pkg::SLOT_EXT_HIGH])
	);
	ipr_prio_reg #(.WMASK(ipr_pkg::MASK_DMA)) u_dma (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(slot_wr[ipr_pkg::SLOT_DMA]),
		.wr_strb(st_r.wstrb),
		.wr_data(st_r.wdata),
		.value(prio[ipr_pkg::SLOT_DMA])
	);
	ipr_prio_reg #(.WMASK(ipr_pkg::MASK_TIMER01)) u_timer01 (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(slot_wr[ipr_pkg::SLOT_TIMER01]),
		.wr_strb(st_r.wstrb),
		.wr_data(st_r.wdata),
		.value(prio[ipr_pkg::SLOT_TIMER01])
	);
	ipr_prio_reg #(.WMASK(ipr_pkg::MASK_TIMER2)) u_timer2 (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(slot_wr[ipr_pkg::SLOT_TIMER2]),
		.wr_strb(st_r.wstrb),
		.wr_data(st_r.wdata),
		.value(prio[ipr_pkg::SLOT_TIMER2])
	);
	ipr_prio_reg #(.WMASK(ipr_pkg::MASK_SERIAL)) u_serial (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(slot_wr[ipr_pkg::SLOT_SERIAL]),
		.wr_strb(st_r.wstrb),
		.wr_data(st_r.wdata),
		.value(prio[ipr_pkg::SLOT_SERIAL])
	);
	ipr_prio_reg #(.WMASK(ipr_pkg::MASK_CONV_CMP)) u_conv_cmp (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(slot_wr[ipr_pkg::SLOT_CONV_CMP]),
		.wr_strb(st_r.wstrb),
		.wr_data(st_r.wdata),
		.value(prio[ipr_pkg::SLOT_CONV_CMP])
	);
	ipr_prio_reg #(.WMASK(ipr_pkg::MASK_WDT_BUS)) u_wdt_bus (
		.aclk(aclk),
		.aresetn(aresetn),
		.wr_en(slot_wr[ipr_pkg::SLOT_WDT_BUS]),
		.wr_strb(st_r.wstrb),
		.wr_data(st_r.wdata),
		.value(prio[ipr_pkg::SLOT_WDT_BUS])
	);

	// Field fan-out to the arbiter; all come straight from flip-flops
	always_comb begin
		external_request_0_prio = field(prio[ipr_pkg::SLOT_EXT_LOW],
			ipr_pkg::FLD_3);
		external_request_1_prio = field(prio[ipr_pkg::SLOT_EXT_LOW],
			ipr_pkg::FLD_2);
		external_request_2_prio = field(prio[ipr_pkg::SLOT_EXT_LOW],
			ipr_pkg::FLD_1);
		external_request_3_prio = field(prio[ipr_pkg::SLOT_EXT_LOW],
			ipr_pkg::FLD_0);
		external_request_6_prio = field(prio[ipr_pkg::SLOT_EXT_HIGH],
			ipr_pkg::FLD_1);
		external_request_7_prio = field(prio[ipr_pkg::SLOT_EXT_HIGH],
			ipr_pkg::FLD_0);
		dma_channel_0_prio = field(prio[ipr_pkg::SLOT_DMA],
			ipr_pkg::FLD_3);
		dma_channel_1_prio = field(prio[ipr_pkg::SLOT_DMA], ipr_pkg::FLD_2);
		timer_channel_0_prio_a = field(prio[ipr_pkg::SLOT_TIMER01],
			ipr_pkg::FLD_3);
		timer_channel_0_prio_b = field(prio[ipr_pkg::SLOT_TIMER01],
			ipr_pkg::FLD_2);
		timer_channel_1_prio_a = field(prio[ipr_pkg::SLOT_TIMER01],
			ipr_pkg::FLD_1);
		timer_channel_1_prio_b = field(prio[ipr_pkg::SLOT_TIMER01],
			ipr_pkg::FLD_0);
		timer_channel_2_prio_a = field(prio[ipr_pkg::SLOT_TIMER2],
			ipr_pkg::FLD_3);
		timer_channel_2_prio_b = field(prio[ipr_pkg::SLOT_TIMER2],
			ipr_pkg::FLD_2);
		serial_channel_0_prio = field(prio[ipr_pkg::SLOT_SERIAL],
			ipr_pkg::FLD_1);
		serial_channel_1_prio = field(prio[ipr_pkg::SLOT_SERIAL],
			ipr_pkg::FLD_0);
		converter_prio = field(prio[ipr_pkg::SLOT_CONV_CMP],
			ipr_pkg::FLD_3);
		compare_timer_0_prio = field(prio[ipr_pkg::SLOT_CONV_CMP],
			ipr_pkg::FLD_1);
		compare_timer_1_prio = field(prio[ipr_pkg::SLOT_CONV_CMP],
			ipr_pkg::FLD_0);
		watchdog_buscontrol_prio = field(prio[ipr_pkg::SLOT_WDT_BUS],
			ipr_pkg::FLD_3);
	end

endmodule

// file: ipr_bank_assertions.sv
// Concurrent checks on the ports of the priority register bank
module ipr_bank_assertions (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bus handshakes
	input wire logic s_axi_awvalid,
	input wire logic s_axi_awready,
	input wire logic s_axi_wvalid,
	input wire logic s_axi_wready,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Sampled priority levels
	input wire logic [3:0] external_request_0_prio,
	input wire logic [3:0] dma_channel_1_prio,
	input wire logic [3:0] converter_prio,
	input wire logic [3:0] watchdog_buscontrol_prio
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge aclk);
	endclocking
	logic [15:0] prio;
	assign prio = {external_request_0_prio, dma_channel_1_prio,
		converter_prio, watchdog_buscontrol_prio};
	sequence s_both_taken;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
	endsequence
	sequence s_ar_taken;
		s_axi_arvalid && s_axi_arready;
	endsequence
	a_reset_clears_bank: assert property (!aresetn |=> prio == 16'h0
		&& !s_axi_bvalid && !s_axi_rvalid) else $error("reset state wrong");
	a_prio_moves_write: assert property (disable iff (!aresetn)
		$changed(prio) |-> s_axi_bvalid || !$past(aresetn))
		else $error("priority changed without a write");
	a_write_resp_time: assert property (disable iff (!aresetn)
		s_both_taken |-> ##2 s_axi_bvalid) else $error("write answer late");
	a_read_answer_next: assert property (disable iff (!aresetn)
		s_ar_taken |=> s_axi_rvalid && !s_axi_arready)
		else $error("read answer late");
	a_rdata_holds_wait: assert property (disable iff (!aresetn)
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read data dropped");
	a_upper_half_zero: assert property (disable iff (!aresetn)
		s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0)
		else $error("upper read half not zero");
	a_decerr_reads_zero: assert property (disable iff (!aresetn)
		s_axi_rvalid && s_axi_rresp == ipr_pkg::RESP_DECERR
		|-> s_axi_rdata == 32'h0) else $error("unmapped read not zero");
	a_busy_blocks_aw: assert property (disable iff (!aresetn)
		s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while answer pending");
endmodule

bind ipr_priority_bank ipr_bank_assertions i_chk (.aclk, .aresetn,
	.s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
	.s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
	.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .external_request_0_prio,
	.dma_channel_1_prio, .converter_prio, .watchdog_buscontrol_prio);

// file: ipr_priority_bank_bench.sv
// Self-checking bench for the priority register bank
module ipr_priority_bank_bench;
	timeunit 1ns;
	timeprecision 1ps;
	typedef struct packed {
		logic [2:0] slot;
		logic [31:0] d;
		logic [3:0] s;
		logic [15:0] e;
	} ipr_tb_row_t;
	localparam logic [31:0] IDX [8] = '{ipr_pkg::IDX_EXT_LOW,
		ipr_pkg::IDX_EXT_HIGH, ipr_pkg::IDX_DMA, ipr_pkg::IDX_TIMER01,
		ipr_pkg::IDX_TIMER2, ipr_pkg::IDX_SERIAL, ipr_pkg::IDX_CONV_CMP,
		ipr_pkg::IDX_WDT_BUS};
	// Later rows build on earlier ones: byte writes merge into a5c3
	localparam ipr_tb_row_t ROWS [11] = '{
		'{3'h0, 32'h0000a5c3, 4'hf, 16'ha5c3},
		'{3'h1, 32'hffffffff, 4'hf, 16'h00ff},
		'{3'h2, 32'h0000ffff, 4'h3, 16'hff00},
		'{3'h3, 32'hdead1234, 4'hf, 16'h1234},
		'{3'h4, 32'h0000ffff, 4'hf, 16'hff00},
		'{3'h5, 32'h0000ffff, 4'hf, 16'h00ff},
		'{3'h6, 32'h0000ffff, 4'hf, 16'hf0ff},
		'{3'h7, 32'h0000ffff, 4'hf, 16'hf000},
		'{3'h0, 32'h0000007e, 4'h1, 16'ha57e},
		'{3'h0, 32'h00001200, 4'h2, 16'h127e},
		'{3'h7, 32'h00005fff, 4'hc, 16'hf000}};
	logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid;
	logic s_axi_wready, s_axi_bvalid, s_axi_bready, s_axi_arvalid;
	logic s_axi_arready, s_axi_rvalid, s_axi_rready;
	logic [17:0] s_axi_awaddr, s_axi_araddr;
	logic [2:0] s_axi_awprot, s_axi_arprot;
	logic [31:0] s_axi_wdata, s_axi_rdata, rd_val;
	logic [3:0] s_axi_wstrb;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	logic [3:0] external_request_0_prio, external_request_1_prio;
	logic [3:0] external_request_2_prio, external_request_3_prio;
	logic [3:0] external_request_6_prio, external_request_7_prio;
	logic [3:0] dma_channel_0_prio, dma_channel_1_prio;
	logic [3:0] timer_channel_0_prio_a, timer_channel_0_prio_b;
	logic [3:0] timer_channel_1_prio_a, timer_channel_1_prio_b;
	logic [3:0] timer_channel_2_prio_a, timer_channel_2_prio_b;
	logic [3:0] serial_channel_0_prio, serial_channel_1_prio;
	logic [3:0] converter_prio, compare_timer_0_prio, compare_timer_1_prio;
	logic [3:0] watchdog_buscontrol_prio;
	logic [15:0] v [8];
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	// Priority outputs regrouped as the registers lay them out
	assign v[0] = {external_request_0_prio, external_request_1_prio,
		external_request_2_prio, external_request_3_prio};
	assign v[1] = {8'h00, external_request_6_prio, external_request_7_prio};
	assign v[2] = {dma_channel_0_prio, dma_channel_1_prio, 8'h00};
	assign v[3] = {timer_channel_0_prio_a, timer_channel_0_prio_b,
		timer_channel_1_prio_a, timer_channel_1_prio_b};
	assign v[4] = {timer_channel_2_prio_a, timer_channel_2_prio_b, 8'h00};
	assign v[5] = {8'h00, serial_channel_0_prio, serial_channel_1_prio};
	assign v[6] = {converter_prio, 4'h0, compare_timer_0_prio,
		compare_timer_1_prio};
	assign v[7] = {watchdog_buscontrol_prio, 12'h000};
	ipr_priority_bank i_dut (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
		.s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
		.s_axi_rready, .external_request_0_prio, .external_request_1_prio,
		.external_request_2_prio, .external_request_3_prio,
		.external_request_6_prio, .external_request_7_prio,
		.dma_channel_0_prio, .dma_channel_1_prio, .timer_channel_0_prio_a,
		.timer_channel_0_prio_b, .timer_channel_1_prio_a,
		.timer_channel_1_prio_b, .timer_channel_2_prio_a,
		.timer_channel_2_prio_b, .serial_channel_0_prio,
		.serial_channel_1_prio, .converter_prio, .compare_timer_0_prio,
		.compare_timer_1_prio, .watchdog_buscontrol_prio);
	initial begin
		aclk = 1'b0;
		forever #5 aclk = ~aclk;
	end
	task stop_test();
		$display("checks %0d mismatches %0d", check_count, n_errors);
		if (n_errors == 0 && check_count > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			n_errors++;
			stop_test();
		end
	end
	task check(input logic [31:0] got, input logic [31:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	function automatic logic [17:0] adr(input logic [2:0] s);
		return {IDX[s][15:0], 2'b00};
	endfunction
	task wr(input logic [17:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] er);
		logic got_b;
		logic aw_hit;
		logic w_hit;
		logic [1:0] resp_seen;
		got_b = 1'b0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		// Outputs are read mid-cycle, clear of the edge that moves them
		while (!got_b) begin
			@(negedge aclk);
			aw_hit = s_axi_awvalid && s_axi_awready;
			w_hit = s_axi_wvalid && s_axi_wready;
			got_b = (s_axi_bvalid === 1'b1);
			resp_seen = s_axi_bresp;
			@(posedge aclk);
			if (aw_hit) s_axi_awvalid <= 1'b0;
			if (w_hit) s_axi_wvalid <= 1'b0;
			if (got_b) begin
				s_axi_bready <= 1'b0;
				check(resp_seen, er);
			end
		end
	endtask
	// Ready is raised a cycle late so the read answer must stand and wait
	task rd(input logic [17:0] a, input logic [1:0] er);
		logic got_r;
		logic ar_hit;
		logic r_seen;
		logic [1:0] resp_seen;
		got_r = 1'b0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		while (!got_r) begin
			@(negedge aclk);
			ar_hit = s_axi_arvalid && s_axi_arready;
			r_seen = (s_axi_rvalid === 1'b1);
			got_r = r_seen && (s_axi_rready === 1'b1);
			resp_seen = s_axi_rresp;
			if (got_r) rd_val = s_axi_rdata;
			@(posedge aclk);
			if (ar_hit) s_axi_arvalid <= 1'b0;
			if (got_r) begin
				s_axi_rready <= 1'b0;
				check(resp_seen, er);
			end else if (r_seen) begin
				s_axi_rready <= 1'b1;
			end
		end
	endtask
	task reset_and_check_zero();
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		for (int i = 0; i < 8; i++) begin
			rd(adr(3'(i)), ipr_pkg::RESP_OKAY);
			check(rd_val, 32'h0);
			check(v[i], 16'h0);
		end
		$display("reset test done");
	endtask
	initial begin
		{aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
		{s_axi_arvalid, s_axi_rready, s_axi_awprot, s_axi_arprot} = 8'h00;
		{s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = 72'h0;
		reset_and_check_zero();
		foreach (ROWS[i]) begin
			wr(adr(ROWS[i].slot), ROWS[i].d, ROWS[i].s, ipr_pkg::RESP_OKAY);
			check(v[ROWS[i].slot], ROWS[i].e);
			rd(adr(ROWS[i].slot), ipr_pkg::RESP_OKAY);
			check(rd_val, {16'h0, ROWS[i].e});
		end
		$display("table test done");
		wr(18'h00000, 32'hffffffff, 4'hf, ipr_pkg::RESP_DECERR);
		rd(18'h00000, ipr_pkg::RESP_DECERR);
		check(rd_val, 32'h0);
		check(v[0], 16'h127e);
		$display("unmapped test done");
		reset_and_check_zero();
		stop_test();
	end
endmodule
